/* core/twc_pkg.sv */
/*
 * Package for the timer waveform-output block: register map, field layout,
 * reset values, modes and the bus carriers.
 * Assumes a single 20 MHz clock and an APB register bus with 32-bit data.
 */
package twc_pkg;

	localparam logic [7:0] TWC_MAX = 8'hFF;
	localparam logic [7:0] TWC_BOTTOM = 8'h00;

	// Register byte offsets
	localparam logic [7:0] TWC_OFS_CTRL_A = 8'h00;
	localparam logic [7:0] TWC_OFS_CTRL_B = 8'h04;
	localparam logic [7:0] TWC_OFS_COUNT = 8'h08;
	localparam logic [7:0] TWC_OFS_CMP_A = 8'h0C;
	localparam logic [7:0] TWC_OFS_CMP_B = 8'h10;
	localparam logic [7:0] TWC_OFS_STATUS = 8'h14;
	localparam logic [7:0] TWC_OFS_MASK = 8'h18;
	localparam logic [7:0] TWC_OFS_PINCFG = 8'h1C;

	// Field positions
	localparam int TWC_CA_MODE_A = 6;
	localparam int TWC_CA_MODE_B = 4;
	localparam int TWC_CA_WAVE_LO = 0;
	localparam int TWC_CB_WAVE_HI = 3;
	localparam int TWC_CB_FORCE_A = 7;
	localparam int TWC_CB_FORCE_B = 6;
	localparam int TWC_ST_OVF = 0;
	localparam int TWC_ST_MATCH_A = 1;
	localparam int TWC_ST_MATCH_B = 2;

	// Writable bits; everything else reads as zero
	localparam logic [7:0] TWC_CTRL_A_WMASK = 8'hF3;
	localparam logic [7:0] TWC_CTRL_B_RMASK = 8'h0F;
	localparam logic [7:0] TWC_CTRL_A_RESET = 8'h00;
	localparam logic [7:0] TWC_CTRL_B_RESET = 8'h00;
	localparam logic [2:0] TWC_STATUS_RESET = 3'h0;

	localparam logic [2:0] TWC_WAVE_NORMAL = 3'h0;
	localparam logic [2:0] TWC_WAVE_PC_FF = 3'h1;
	localparam logic [2:0] TWC_WAVE_CTC = 3'h2;
	localparam logic [2:0] TWC_WAVE_FAST_FF = 3'h3;
	localparam logic [2:0] TWC_WAVE_PC_CMP = 3'h5;
	localparam logic [2:0] TWC_WAVE_FAST_CMP = 3'h7;

	localparam logic [1:0] TWC_OUT_OFF = 2'h0;
	localparam logic [1:0] TWC_OUT_TOGGLE = 2'h1;
	localparam logic [1:0] TWC_OUT_CLEAR = 2'h2;
	localparam logic [1:0] TWC_OUT_SET = 2'h3;

	// Prescaler divisions, selected by tick_source_sel 2..7
	localparam int TWC_DIV_8 = 8;
	localparam int TWC_DIV_32 = 32;
	localparam int TWC_DIV_64 = 64;
	localparam int TWC_DIV_128 = 128;
	localparam int TWC_DIV_256 = 256;
	localparam int TWC_DIV_1024 = 1024;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} twc_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} twc_apb_rsp_t;

	typedef struct packed {
		logic level;
		logic enable;
	} twc_pin_t;

endpackage : twc_pkg

/* core/twc_prescaler.sv */
/*
 * Tick source for the counter: stopped, every clock, or a prescaled enable.
 * Assumes the clock select comes from a register in the same clock domain.
 */
module twc_prescaler
	import twc_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [2:0] tickSourceSel,
	output logic timerTick
);

	typedef struct packed {
		logic [9:0] count;
		logic tick;
	} twc_pre_state_t;

	twc_pre_state_t state;
	twc_pre_state_t next_state;

	function automatic logic wrapAt(input logic [9:0] cnt, input int div);
		wrapAt = (cnt[9:0] == 10'(div - 1));
	endfunction : wrapAt

	always_comb begin
		next_state = state;
		next_state.count = state.count + 10'h001;
		// One free-running divider serves every prescaled rate
		case (tickSourceSel)
			3'h0: next_state.tick = 1'b0;
			3'h1: next_state.tick = 1'b1;
			3'h2: next_state.tick = (state.count[2:0] == 3'h7);
			3'h3: next_state.tick = (state.count[4:0] == 5'h1F);
			3'h4: next_state.tick = (state.count[5:0] == 6'h3F);
			3'h5: next_state.tick = (state.count[6:0] == 7'h7F);
			3'h6: next_state.tick = (state.count[7:0] == 8'hFF);
			3'h7: next_state.tick = wrapAt(state.count, TWC_DIV_1024);
			default: next_state.tick = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign timerTick = state.tick;

	chk_stopped_no_tick: assert property (@(posedge mclk) disable iff (reset)
		(tickSourceSel == 3'h0) ##1 (tickSourceSel == 3'h0) |=> !timerTick)
		else $error("tick while stopped");

endmodule : twc_prescaler

/* core/twc_waveform.sv */
/*
 * Timer waveform-output and mode control: 8-bit counter, two compare channels,
 * six waveform modes, APB register file and one level interrupt.
 * Assumes synchronous timer clocking on mclk; pins are driven by an outside
 * port mux that uses the level and enable given here.
 */
// Local design decisions: the APB register port and the register addresses.
module twc_waveform
	import twc_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire twc_apb_req_t apbReq,
	output twc_apb_rsp_t apbRsp,
	output twc_pin_t compareOutA,
	output twc_pin_t compareOutB,
	output logic irq
);

	typedef struct packed {
		logic [7:0] controlRegA;
		logic [3:0] controlRegB;
		logic [7:0] counterValue;
		logic [7:0] compareValueA;
		logic [7:0] compareValueB;
		logic [7:0] bufferA;
		logic [7:0] bufferB;
		logic countDown;
		logic [2:0] status;
		logic [2:0] mask;
		logic [1:0] pinDir;
		logic outA;
		logic outB;
		logic blockMatch;
		twc_apb_rsp_t rsp;
		twc_pin_t pinA;
		twc_pin_t pinB;
		logic irq;
	} twc_state_t;

	twc_state_t state;
	twc_state_t next_state;
	logic timerTick;

	twc_prescaler u_prescaler (
		.mclk(mclk),
		.reset(reset),
		.tickSourceSel(state.controlRegB[2:0]),
		.timerTick(timerTick)
	);

	// New output level for one channel at this tick
	function automatic logic waveStep(input logic cur, input logic [1:0] mode,
		input logic isPwm, input logic isFast, input logic hiBit, input logic allowToggle,
		input logic match, input logic atTop, input logic atBottom, input logic down,
		input logic cmpIsTop);
		logic res;
		logic hit;
		res = cur;
		hit = match;
		if (isPwm && mode[1] && cmpIsTop) begin
			hit = 1'b0;
		end
		if (!isPwm) begin
			case (mode)
				TWC_OUT_TOGGLE: if (hit) res = ~cur;
				TWC_OUT_CLEAR: if (hit) res = 1'b0;
				TWC_OUT_SET: if (hit) res = 1'b1;
				default: res = cur;
			endcase
		end else if (mode == TWC_OUT_TOGGLE) begin
			if (allowToggle && hiBit && hit) begin
				res = ~cur;
			end
		end else if (mode[1]) begin
			if (isFast) begin
				// Set or clear at TOP happens even when the match is ignored
				if (atTop) res = ~mode[0];
				else if (hit) res = mode[0];
			end else begin
				if (hit) res = mode[0] ^ down;
				else if (cmpIsTop && atTop) res = ~mode[0];
				else if (atBottom && cmpIsTop) res = ~mode[0];
			end
		end
		return res;
	endfunction : waveStep

	logic [2:0] waveSel;
	logic isPwm;
	logic isFast;
	logic [7:0] topValue;
	logic atTop;
	logic matchA;
	logic matchB;
	logic ovfEvent;
	logic accessPhase;
	logic [31:0] readData;
	logic [2:0] hwSet;

	always_comb begin
		waveSel = {state.controlRegB[TWC_CB_WAVE_HI],
			state.controlRegA[TWC_CA_WAVE_LO +: 2]};
		isPwm = waveSel[0];
		isFast = (waveSel == TWC_WAVE_FAST_FF) || (waveSel == TWC_WAVE_FAST_CMP);
		// Reserved modes 4 and 6 count like normal with TOP at MAX
		topValue = (waveSel == TWC_WAVE_CTC || waveSel == TWC_WAVE_PC_CMP ||
			waveSel == TWC_WAVE_FAST_CMP) ? state.compareValueA : TWC_MAX;
		atTop = (state.counterValue == topValue);
		matchA = (state.counterValue == state.compareValueA) && !state.blockMatch;
		matchB = (state.counterValue == state.compareValueB) && !state.blockMatch;
		ovfEvent = 1'b0;
		if (timerTick) begin
			if (waveSel == TWC_WAVE_PC_FF || waveSel == TWC_WAVE_PC_CMP) begin
				ovfEvent = state.countDown && (state.counterValue == TWC_BOTTOM);
			end else if (waveSel == TWC_WAVE_FAST_CMP) begin
				ovfEvent = atTop;
			end else begin
				ovfEvent = (state.counterValue == TWC_MAX);
			end
		end
		hwSet = '0;
		hwSet[TWC_ST_OVF] = ovfEvent;
		hwSet[TWC_ST_MATCH_A] = timerTick && matchA;
		hwSet[TWC_ST_MATCH_B] = timerTick && matchB;
		accessPhase = apbReq.psel && apbReq.penable;

		case (apbReq.paddr)
			TWC_OFS_CTRL_A: readData = {24'h0, state.controlRegA & TWC_CTRL_A_WMASK};
			TWC_OFS_CTRL_B: readData = {28'h0, state.controlRegB};
			TWC_OFS_COUNT: readData = {24'h0, state.counterValue};
			TWC_OFS_CMP_A: readData = {24'h0, state.bufferA};
			TWC_OFS_CMP_B: readData = {24'h0, state.bufferB};
			TWC_OFS_STATUS: readData = {29'h0, state.status};
			TWC_OFS_MASK: readData = {29'h0, state.mask};
			TWC_OFS_PINCFG: readData = {30'h0, state.pinDir};
			default: readData = 32'h0;
		endcase

		next_state = state;
		next_state.rsp.pready = accessPhase && !state.rsp.pready;
		next_state.rsp.pslverr = 1'b0;
		next_state.rsp.prdata = state.rsp.prdata;
		if (accessPhase && !state.rsp.pready) begin
			next_state.rsp.prdata = apbReq.pwrite ? 32'h0 : readData;
			next_state.rsp.pslverr = (readData == 32'h0) && (apbReq.paddr > TWC_OFS_PINCFG);
		end

		if (timerTick) begin
			next_state.blockMatch = 1'b0;
			next_state.outA = waveStep(state.outA, state.controlRegA[TWC_CA_MODE_A +: 2],
				isPwm, isFast, waveSel[2], 1'b1, matchA, atTop,
				state.counterValue == TWC_BOTTOM, state.countDown,
				state.compareValueA == topValue);
			next_state.outB = waveStep(state.outB, state.controlRegA[TWC_CA_MODE_B +: 2],
				isPwm, isFast, waveSel[2], 1'b0, matchB, atTop,
				state.counterValue == TWC_BOTTOM, state.countDown,
				state.compareValueB == topValue);
			if (isPwm && !isFast) begin
				if (atTop && !state.countDown) begin
					next_state.countDown = 1'b1;
					next_state.counterValue = state.counterValue - 8'h01;
					next_state.compareValueA = state.bufferA;
					next_state.compareValueB = state.bufferB;
				end else if (state.countDown && state.counterValue == TWC_BOTTOM) begin
					next_state.countDown = 1'b0;
					next_state.counterValue = state.counterValue + 8'h01;
				end else begin
					next_state.counterValue = state.countDown ?
						state.counterValue - 8'h01 : state.counterValue + 8'h01;
				end
			end else if (atTop) begin
				next_state.countDown = 1'b0;
				next_state.counterValue = TWC_BOTTOM;
				if (isFast) begin
					next_state.compareValueA = state.bufferA;
					next_state.compareValueB = state.bufferB;
				end
			end else begin
				next_state.countDown = 1'b0;
				next_state.counterValue = state.counterValue + 8'h01;
			end
		end

		// Set wins over a write-one clear in the same cycle
		next_state.status = state.status | hwSet;
		// A write lands at the edge where the master sees pready high
		if (accessPhase && state.rsp.pready && apbReq.pwrite) begin
			case (apbReq.paddr)
				TWC_OFS_CTRL_A: next_state.controlRegA = apbReq.pwdata[7:0] & TWC_CTRL_A_WMASK;
				TWC_OFS_CTRL_B: begin
					next_state.controlRegB = apbReq.pwdata[3:0] & TWC_CTRL_B_RMASK[3:0];
					// Force strobes act only outside PWM and raise no flag
					if (!isPwm && apbReq.pwdata[TWC_CB_FORCE_A]) begin
						next_state.outA = waveStep(state.outA,
							state.controlRegA[TWC_CA_MODE_A +: 2], 1'b0, 1'b0, 1'b0,
							1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
					end
					if (!isPwm && apbReq.pwdata[TWC_CB_FORCE_B]) begin
						next_state.outB = waveStep(state.outB,
							state.controlRegA[TWC_CA_MODE_B +: 2], 1'b0, 1'b0, 1'b0,
							1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
					end
				end
				TWC_OFS_COUNT: begin
					next_state.counterValue = apbReq.pwdata[7:0];
					next_state.blockMatch = 1'b1;
				end
				TWC_OFS_CMP_A: begin
					next_state.bufferA = apbReq.pwdata[7:0];
					if (!isPwm) next_state.compareValueA = apbReq.pwdata[7:0];
				end
				TWC_OFS_CMP_B: begin
					next_state.bufferB = apbReq.pwdata[7:0];
					if (!isPwm) next_state.compareValueB = apbReq.pwdata[7:0];
				end
				TWC_OFS_STATUS: next_state.status = (state.status & ~apbReq.pwdata[2:0]) | hwSet;
				TWC_OFS_MASK: next_state.mask = apbReq.pwdata[2:0];
				TWC_OFS_PINCFG: next_state.pinDir = apbReq.pwdata[1:0];
				default: next_state.mask = state.mask;
			endcase
		end

		next_state.pinA.level = state.outA;
		// PWM toggle mode without the high mode bit leaves pin A disconnected
		next_state.pinA.enable = (state.controlRegA[TWC_CA_MODE_A +: 2] != TWC_OUT_OFF)
			&& !(isPwm && state.controlRegA[TWC_CA_MODE_A +: 2] == TWC_OUT_TOGGLE
			&& !waveSel[2]) && state.pinDir[0];
		next_state.pinB.level = state.outB;
		next_state.pinB.enable = (state.controlRegA[TWC_CA_MODE_B +: 2] != TWC_OUT_OFF)
			&& state.pinDir[1];
		next_state.irq = |(state.status & state.mask);
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign apbRsp = state.rsp;
	assign compareOutA = state.pinA;
	assign compareOutB = state.pinB;
	assign irq = state.irq;

	logic [2:0] waveSelNow;
	assign waveSelNow = {state.controlRegB[TWC_CB_WAVE_HI], state.controlRegA[1:0]};

	chk_pin_a_route: assert property (@(posedge mclk) disable iff (reset)
		##1 compareOutA.enable == $past(state.controlRegA[7:6] != 2'h0
		&& !(waveSelNow[0] && state.controlRegA[7:6] == 2'h1 && !waveSelNow[2])
		&& state.pinDir[0]))
		else $error("pin A enable wrong");
	chk_pin_b_dir: assert property (@(posedge mclk) disable iff (reset)
		!state.pinDir[1] |=> !compareOutB.enable)
		else $error("pin B driven without direction");
	chk_reserved_zero: assert property (@(posedge mclk) disable iff (reset)
		state.controlRegA[3:2] == 2'h0)
		else $error("reserved bits set");
	chk_ctc_clear: assert property (@(posedge mclk) disable iff (reset)
		(timerTick && waveSelNow == 3'h2 && state.counterValue == state.compareValueA
		&& !(accessPhase && apbReq.pwrite)) |=> state.counterValue == 8'h00 && state.status[1])
		else $error("clear-on-match failed");
	chk_nonpwm_set: assert property (@(posedge mclk) disable iff (reset)
		(timerTick && !waveSelNow[0] && state.controlRegA[7:6] == 2'h3 && matchA
		&& !(accessPhase && apbReq.pwrite)) |=> state.outA)
		else $error("set on match failed");
	chk_fast_top: assert property (@(posedge mclk) disable iff (reset)
		(timerTick && waveSelNow == 3'h3 && state.counterValue == 8'hFF
		&& state.controlRegA[7:6] == 2'h2 && !(accessPhase && apbReq.pwrite)) |=> state.outA)
		else $error("fast PWM TOP set failed");
	chk_normal_ovf: assert property (@(posedge mclk) disable iff (reset)
		(timerTick && waveSelNow == 3'h0 && state.counterValue == 8'hFF)
		|=> state.status[0] && state.counterValue == 8'h00)
		else $error("normal overflow missed");
	chk_pc_bottom_flag: assert property (@(posedge mclk) disable iff (reset)
		(timerTick && waveSelNow == 3'h1 && !state.countDown && state.counterValue == 8'h00)
		|=> !$rose(state.status[0]))
		else $error("phase-correct flag on upcount");
	chk_irq_level: assert property (@(posedge mclk) disable iff (reset)
		##1 irq == |($past(state.status) & $past(state.mask)))
		else $error("irq level wrong");

endmodule : twc_waveform

/* bench/test_timer2_waveform_output_control.sv */
/*
 * Self-checking bench for the timer waveform-output block: registers, forced
 * matches, clear-on-match, normal, fast and phase-correct waveforms, interrupt.
 * Assumes twc_pkg and twc_waveform are compiled before this file.
 */
module test_timer2_waveform_output_control
	import twc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic mclk = 1'b0;
	logic reset = 1'b1;
	twc_apb_req_t req = '0;
	twc_apb_rsp_t rsp;
	twc_pin_t outA;
	twc_pin_t outB;
	logic irq;
	int nErrors = 0;
	int checked = 0;
	logic [31:0] q;
	logic e;

	always #25 mclk = ~mclk;

	twc_waveform uut (
		.mclk(mclk),
		.reset(reset),
		.apbReq(req),
		.apbRsp(rsp),
		.compareOutA(outA),
		.compareOutB(outB),
		.irq(irq)
	);

	task automatic completeRun();
		$display("Counts: %0d mismatches, %0d comparisons", nErrors, checked);
		if (nErrors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : completeRun

	task automatic checkWord(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			nErrors++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : checkWord

	task automatic checkBit(input logic got, input logic exp, input string m);
		checked++;
		if (got !== exp) begin
			nErrors++;
			$display("MISMATCH at %0t: %s got %b expected %b", $time, m, got, exp);
		end
	endtask : checkBit

	task automatic checkCount(input int got, input int exp, input string m);
		checked++;
		if (got != exp) begin
			nErrors++;
			$display("MISMATCH at %0t: %s got %0d expected %0d", $time, m, got, exp);
		end
	endtask : checkCount

	task automatic waitClk(input int n);
		repeat (n) @(posedge mclk);
	endtask : waitClk

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {24'h0, d}};
		@(posedge mclk);
		req.penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 16);
		checkBit(rsp.pready, 1'b1, "pready");
		q = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	// High cycles over a whole number of periods do not depend on phase
	task automatic duty(input logic chB, input int win, input int exp);
		int h;
		h = 0;
		repeat (win) begin
			@(posedge mclk);
			if ((chB ? outB.level : outA.level) === 1'b1) h++;
		end
		checkCount(h, exp, "high cycles");
	endtask : duty

	task automatic testRegs();
		apb(1'b0, TWC_OFS_CTRL_A, 8'h00);
		checkWord(q, 32'h0, "ctrl A reset");
		apb(1'b0, TWC_OFS_CTRL_B, 8'h00);
		checkWord(q, 32'h0, "ctrl B reset");
		apb(1'b1, TWC_OFS_CTRL_A, 8'hFF);
		apb(1'b0, TWC_OFS_CTRL_A, 8'h00);
		checkWord(q, 32'h000000F3, "ctrl A readback");
		apb(1'b1, TWC_OFS_CTRL_A, 8'h00);
		apb(1'b0, 8'h20, 8'h00);
		checkBit(e, 1'b1, "unmapped error");
		checkWord(q, 32'h0, "unmapped data");
	endtask : testRegs

	// Tick stopped, so only the force strobe makes a match
	task automatic testForce(input logic chB);
		logic [1:0] modes [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
		logic lv [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
		int sh;
		sh = chB ? TWC_CA_MODE_B : TWC_CA_MODE_A;
		apb(1'b1, TWC_OFS_PINCFG, 8'h03);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, TWC_OFS_CTRL_A, {6'h0, modes[i]} << sh);
			apb(1'b1, TWC_OFS_CTRL_B, chB ? 8'h40 : 8'h80);
			waitClk(3);
			checkBit(chB ? outB.level : outA.level, lv[i], "forced level");
			checkBit(chB ? outB.enable : outA.enable, 1'b1, "pin on");
		end
		apb(1'b1, TWC_OFS_PINCFG, 8'h00);
		waitClk(3);
		checkBit(chB ? outB.enable : outA.enable, 1'b0, "no direction");
		apb(1'b1, TWC_OFS_PINCFG, 8'h03);
		apb(1'b1, TWC_OFS_CTRL_A, 8'h00);
		waitClk(3);
		checkBit(chB ? outB.enable : outA.enable, 1'b0, "mode off");
	endtask : testForce

	task automatic testCtc();
		apb(1'b1, TWC_OFS_CMP_A, 8'h04);
		apb(1'b1, TWC_OFS_COUNT, 8'h00);
		apb(1'b1, TWC_OFS_STATUS, 8'h07);
		apb(1'b1, TWC_OFS_CTRL_A, 8'h42);
		apb(1'b1, TWC_OFS_CTRL_B, 8'h01);
		waitClk(10);
		duty(1'b0, 100, 50);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, TWC_OFS_COUNT, 8'h00);
			checkBit(q[7:0] <= 8'h04, 1'b1, "count bound");
		end
		apb(1'b0, TWC_OFS_STATUS, 8'h00);
		checkWord(q, 32'h6, "flags");
		checkBit(irq, 1'b0, "masked irq");
		apb(1'b1, TWC_OFS_MASK, 8'h02);
		waitClk(2);
		checkBit(irq, 1'b1, "irq raised");
		apb(1'b1, TWC_OFS_CTRL_B, 8'h00);
		apb(1'b1, TWC_OFS_STATUS, 8'h02);
		waitClk(2);
		checkBit(irq, 1'b0, "irq cleared");
		apb(1'b0, TWC_OFS_STATUS, 8'h00);
		checkWord(q, 32'h4, "flag cleared");
	endtask : testCtc

	task automatic testNormal();
		logic [31:0] c;
		apb(1'b1, TWC_OFS_MASK, 8'h00);
		apb(1'b1, TWC_OFS_COUNT, 8'h00);
		apb(1'b1, TWC_OFS_STATUS, 8'h07);
		apb(1'b1, TWC_OFS_CTRL_A, 8'h00);
		apb(1'b1, TWC_OFS_CTRL_B, 8'h01);
		waitClk(200);
		apb(1'b0, TWC_OFS_STATUS, 8'h00);
		checkBit(q[TWC_ST_OVF], 1'b0, "early overflow");
		waitClk(100);
		apb(1'b0, TWC_OFS_STATUS, 8'h00);
		checkBit(q[TWC_ST_OVF], 1'b1, "overflow at max");
		apb(1'b1, TWC_OFS_CTRL_B, 8'h00);
		apb(1'b0, TWC_OFS_COUNT, 8'h00);
		c = q;
		waitClk(20);
		apb(1'b0, TWC_OFS_COUNT, 8'h00);
		checkWord(q, c, "stopped count");
	endtask : testNormal

	task automatic testFast();
		logic [7:0] sel [3] = '{8'h03, 8'h02, 8'h01};
		int dv [3] = '{32, 8, 1};
		apb(1'b1, TWC_OFS_CMP_A, 8'h40);
		apb(1'b1, TWC_OFS_CMP_B, 8'h20);
		apb(1'b1, TWC_OFS_CTRL_A, 8'hB3);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, TWC_OFS_CTRL_B, sel[i]);
			waitClk(260 * dv[i]);
			duty(1'b0, 256 * dv[i], 65 * dv[i]);
		end
		duty(1'b1, 256, 223);
		apb(1'b1, TWC_OFS_CTRL_A, 8'h73);
		waitClk(3);
		checkBit(outA.enable, 1'b0, "toggle off");
		apb(1'b1, TWC_OFS_CMP_A, 8'hFF);
		apb(1'b1, TWC_OFS_CTRL_A, 8'hB3);
		waitClk(600);
		duty(1'b0, 256, 256);
		apb(1'b1, TWC_OFS_CMP_A, 8'h09);
		apb(1'b1, TWC_OFS_CMP_B, 8'h04);
		apb(1'b1, TWC_OFS_CTRL_A, 8'h63);
		apb(1'b1, TWC_OFS_CTRL_B, 8'h09);
		waitClk(600);
		duty(1'b0, 20, 10);
		duty(1'b1, 20, 10);
		apb(1'b1, TWC_OFS_STATUS, 8'h07);
		waitClk(12);
		apb(1'b0, TWC_OFS_STATUS, 8'h00);
		checkBit(q[TWC_ST_OVF], 1'b1, "overflow at top");
	endtask : testFast

	task automatic testPhase();
		apb(1'b1, TWC_OFS_CTRL_B, 8'h01);
		apb(1'b1, TWC_OFS_CMP_A, 8'h30);
		apb(1'b1, TWC_OFS_CMP_B, 8'h50);
		apb(1'b1, TWC_OFS_CTRL_A, 8'hB1);
		waitClk(1100);
		duty(1'b0, 510, 96);
		duty(1'b1, 510, 350);
	endtask : testPhase

	initial begin
		waitClk(4);
		reset <= 1'b0;
		testRegs();
		testForce(1'b0);
		testForce(1'b1);
		testCtc();
		testNormal();
		testFast();
		testPhase();
		completeRun();
	end

	// About 25k cycles are needed; the limit leaves ample margin
	initial begin
		waitClk(60000);
		nErrors++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		completeRun();
	end

endmodule : test_timer2_waveform_output_control
